// ---- logic/timed_pattern_unit.sv ----
// Purpose: Register side of the timed pattern unit for ports A and B.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes:   Compare-match inputs are one-cycle pulses from the timer pulse unit.
//
// Overview of operation
// R1: Port A output values register holds pattern bits for groups 0 and 1.
// R2: Port A output bits with copy enable set ignore software writes.
// R3: Port B output values register holds pattern bits for groups 2 and 3.
// R4: Port B output bits with copy enable set ignore software writes.
// R5: Software sets port B direction bits for pattern pins; register write-only.
// R6: Selected trigger copies enabled port A next bits into port A outputs.
// R7: Selected trigger copies enabled port B next bits into port B outputs.
// R8: Port A next pattern clears on reset and hardware standby only.
// R9: Port B next pattern clears on reset and hardware standby only.
// R10: Shared trigger: port A next byte at FFA5, FFA7 reads all ones.
// R11: Split triggers: group 1 nibble at FFA5, group 0 at FFA7, rest ones.
// R12: Shared trigger: port B next byte at FFA4, FFA6 reads all ones.
// R13: Split triggers: group 3 nibble at FFA4, group 2 at FFA6, rest ones.
// R14: Port A enable bit set lets its next bit copy on trigger.
// R15: Port A enable bit clear leaves its output bit unchanged on trigger.
// R16: Port A copy enable clears on reset and hardware standby only.
// R17: Two-bit group select picks timer channel 0 to 3; register resets FF.
// R18: Port B enable bits gate port B copies like port A.
// R19: Software sets port A direction bits for every pattern output pin.
// R20: Shared trigger updates both nibbles of a port in one cycle.
module timed_pattern_unit (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_hw_standby,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  input  wire logic [3:0]  i_compare_match,
  output logic      [7:0]  o_rd_data,
  output logic      [7:0]  o_port_a_pattern,
  output logic      [7:0]  o_port_b_pattern
);

  // ----------------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------------
  logic [7:0] group_trigger_select_q;
  logic [1:0] sel_g0;
  logic [1:0] sel_g1;
  logic [1:0] sel_g2;
  logic [1:0] sel_g3;
  logic       trig_g0;
  logic       trig_g1;
  logic       trig_g2;
  logic       trig_g3;
  logic       a_shared;
  logic       b_shared;

  // Trigger select register, initialised to channel 3 for every group.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      group_trigger_select_q <= tpat_pkg::RESET_TRIGGER_SELECT; // R17
    end else if (i_hw_standby) begin
      group_trigger_select_q <= tpat_pkg::RESET_TRIGGER_SELECT; // R17
    end else if (i_wr_stb && i_addr == tpat_pkg::ADDR_GROUP_TRIGGER_SELECT) begin
      group_trigger_select_q <= i_wr_data;
    end
  end

  // Field extraction and channel pick for each group.
  assign sel_g0  = group_trigger_select_q[tpat_pkg::GROUP0_SEL_LSB +: 2];
  assign sel_g1  = group_trigger_select_q[tpat_pkg::GROUP1_SEL_LSB +: 2];
  assign sel_g2  = group_trigger_select_q[tpat_pkg::GROUP2_SEL_LSB +: 2];
  assign sel_g3  = group_trigger_select_q[tpat_pkg::GROUP3_SEL_LSB +: 2];
  assign trig_g0 = i_compare_match[sel_g0]; // R17
  assign trig_g1 = i_compare_match[sel_g1]; // R17
  assign trig_g2 = i_compare_match[sel_g2]; // R17
  assign trig_g3 = i_compare_match[sel_g3]; // R17

  // Address layout of the next pattern registers follows the shared flag.
  assign a_shared = (sel_g0 == sel_g1);
  assign b_shared = (sel_g2 == sel_g3);

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  logic wr_a_hi_addr;
  logic wr_a_lo_addr;
  logic wr_b_hi_addr;
  logic wr_b_lo_addr;
  logic a_next_wr_hi;
  logic a_next_wr_lo;
  logic b_next_wr_hi;
  logic b_next_wr_lo;
  logic a_out_wr;
  logic b_out_wr;
  logic a_en_wr;
  logic b_en_wr;

  // Strobes for each address of the next pattern pair.
  assign wr_a_hi_addr = i_wr_stb && (i_addr == tpat_pkg::ADDR_PORT_A_NEXT_HI);
  assign wr_a_lo_addr = i_wr_stb && (i_addr == tpat_pkg::ADDR_PORT_A_NEXT_LO);
  assign wr_b_hi_addr = i_wr_stb && (i_addr == tpat_pkg::ADDR_PORT_B_NEXT_HI);
  assign wr_b_lo_addr = i_wr_stb && (i_addr == tpat_pkg::ADDR_PORT_B_NEXT_LO);

  // Shared: the high address takes the whole byte and the low one is inert.
  // Split: each address reaches only its own nibble.
  assign a_next_wr_hi = wr_a_hi_addr; // R10 R11
  assign a_next_wr_lo = a_shared ? wr_a_hi_addr : wr_a_lo_addr; // R10 R11
  assign b_next_wr_hi = wr_b_hi_addr; // R12 R13
  assign b_next_wr_lo = b_shared ? wr_b_hi_addr : wr_b_lo_addr; // R12 R13

  // Output values and copy enable strobes.
  assign a_out_wr = i_wr_stb && (i_addr == tpat_pkg::ADDR_PORT_A_OUTPUT_VALUES);
  assign b_out_wr = i_wr_stb && (i_addr == tpat_pkg::ADDR_PORT_B_OUTPUT_VALUES);
  assign a_en_wr  = i_wr_stb && (i_addr == tpat_pkg::ADDR_PORT_A_COPY_ENABLE);
  assign b_en_wr  = i_wr_stb && (i_addr == tpat_pkg::ADDR_PORT_B_COPY_ENABLE);

  // ----------------------------------------------------------------------
  // Pattern ports
  // ----------------------------------------------------------------------
  logic [7:0] port_a_output_values;
  logic [7:0] port_a_next_pattern;
  logic [7:0] port_a_copy_enable;
  logic [7:0] port_b_output_values;
  logic [7:0] port_b_next_pattern;
  logic [7:0] port_b_copy_enable;

  // Port A: groups 0 (low nibble) and 1 (high nibble).
  pattern_port u_port_a (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_hw_standby (i_hw_standby),
    .i_out_wr     (a_out_wr),
    .i_en_wr      (a_en_wr),
    .i_next_wr_hi (a_next_wr_hi),
    .i_next_wr_lo (a_next_wr_lo),
    .i_wr_data    (i_wr_data),
    .i_trig_lo    (trig_g0),
    .i_trig_hi    (trig_g1),
    .o_out_values (port_a_output_values), // R1
    .o_next       (port_a_next_pattern),
    .o_enable     (port_a_copy_enable)
  );

  // Port B: groups 2 (low nibble) and 3 (high nibble).
  pattern_port u_port_b (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_hw_standby (i_hw_standby),
    .i_out_wr     (b_out_wr),
    .i_en_wr      (b_en_wr),
    .i_next_wr_hi (b_next_wr_hi),
    .i_next_wr_lo (b_next_wr_lo),
    .i_wr_data    (i_wr_data),
    .i_trig_lo    (trig_g2),
    .i_trig_hi    (trig_g3),
    .o_out_values (port_b_output_values), // R3
    .o_next       (port_b_next_pattern),
    .o_enable     (port_b_copy_enable)
  );

  assign o_port_a_pattern = port_a_output_values;
  assign o_port_b_pattern = port_b_output_values;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] rd_data_q;

  // Reserved nibbles and the inert address of a shared pair read as ones.
  always_comb begin
    rd_mux = tpat_pkg::UNMAPPED_READ;
    unique case (i_addr)
      tpat_pkg::ADDR_GROUP_TRIGGER_SELECT: rd_mux = group_trigger_select_q;
      tpat_pkg::ADDR_PORT_B_COPY_ENABLE:   rd_mux = port_b_copy_enable;
      tpat_pkg::ADDR_PORT_A_COPY_ENABLE:   rd_mux = port_a_copy_enable;
      tpat_pkg::ADDR_PORT_A_OUTPUT_VALUES: rd_mux = port_a_output_values;
      tpat_pkg::ADDR_PORT_B_OUTPUT_VALUES: rd_mux = port_b_output_values;
      tpat_pkg::ADDR_PORT_A_NEXT_HI: begin
        rd_mux = a_shared ? port_a_next_pattern
                          : {port_a_next_pattern[7:4], tpat_pkg::RESERVED_NIBBLE}; // R10 R11
      end
      tpat_pkg::ADDR_PORT_A_NEXT_LO: begin
        rd_mux = a_shared ? tpat_pkg::RESERVED_BYTE
                          : {tpat_pkg::RESERVED_NIBBLE, port_a_next_pattern[3:0]}; // R10 R11
      end
      tpat_pkg::ADDR_PORT_B_NEXT_HI: begin
        rd_mux = b_shared ? port_b_next_pattern
                          : {port_b_next_pattern[7:4], tpat_pkg::RESERVED_NIBBLE}; // R12 R13
      end
      tpat_pkg::ADDR_PORT_B_NEXT_LO: begin
        rd_mux = b_shared ? tpat_pkg::RESERVED_BYTE
                          : {tpat_pkg::RESERVED_NIBBLE, port_b_next_pattern[3:0]}; // R12 R13
      end
      default: rd_mux = tpat_pkg::UNMAPPED_READ;
    endcase
  end

  // Read data stand only in the cycle after the read strobe, zero otherwise.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_data_q <= tpat_pkg::UNMAPPED_READ;
    end else if (i_rd_stb) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= tpat_pkg::UNMAPPED_READ;
    end
  end

  assign o_rd_data = rd_data_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  // Enabled low-nibble bits of port A follow the next pattern on a group 0 trigger.
  property p_a_copy_lo;
    @(posedge i_sys_clk) disable iff (i_reset)
      (trig_g0 && !i_hw_standby) |=>
        ((port_a_output_values[3:0] & $past(port_a_copy_enable[3:0]))
         == ($past(port_a_next_pattern[3:0]) & $past(port_a_copy_enable[3:0])));
  endproperty
  a_a_copy_lo: assert property (p_a_copy_lo) else $error("port A group 0 copy wrong"); // R6 R14

  // Disabled port A bits keep their value across a trigger without a write.
  property p_a_blocked;
    @(posedge i_sys_clk) disable iff (i_reset)
      ((trig_g0 || trig_g1) && !a_out_wr && !i_hw_standby) |=>
        ((port_a_output_values & ~$past(port_a_copy_enable))
         == ($past(port_a_output_values) & ~$past(port_a_copy_enable)));
  endproperty
  a_a_blocked: assert property (p_a_blocked) else $error("port A disabled bit changed"); // R15

  // Software writes never move enabled port A bits when no trigger fires.
  property p_a_read_only;
    @(posedge i_sys_clk) disable iff (i_reset)
      (a_out_wr && !trig_g0 && !trig_g1 && !i_hw_standby) |=>
        ((port_a_output_values & $past(port_a_copy_enable))
         == ($past(port_a_output_values) & $past(port_a_copy_enable)));
  endproperty
  a_a_read_only: assert property (p_a_read_only) else $error("port A read-only bit written"); // R2

  // Software writes never move enabled port B bits when no trigger fires.
  property p_b_read_only;
    @(posedge i_sys_clk) disable iff (i_reset)
      (b_out_wr && !trig_g2 && !trig_g3 && !i_hw_standby) |=>
        ((port_b_output_values & $past(port_b_copy_enable))
         == ($past(port_b_output_values) & $past(port_b_copy_enable)));
  endproperty
  a_b_read_only: assert property (p_b_read_only) else $error("port B read-only bit written"); // R4

  // Enabled high-nibble bits of port B follow the next pattern on a group 3 trigger.
  property p_b_copy_hi;
    @(posedge i_sys_clk) disable iff (i_reset)
      (trig_g3 && !i_hw_standby) |=>
        ((port_b_output_values[7:4] & $past(port_b_copy_enable[7:4]))
         == ($past(port_b_next_pattern[7:4]) & $past(port_b_copy_enable[7:4])));
  endproperty
  a_b_copy_hi: assert property (p_b_copy_hi) else $error("port B group 3 copy wrong"); // R7 R18

  // With a shared trigger both nibbles of port B take the next byte together.
  property p_b_shared_both;
    @(posedge i_sys_clk) disable iff (i_reset)
      (b_shared && trig_g2 && port_b_copy_enable == 8'hff && !i_hw_standby) |=>
        (port_b_output_values == $past(port_b_next_pattern));
  endproperty
  a_b_shared_both: assert property (p_b_shared_both) else $error("port B nibbles split"); // R20

  // Hardware standby clears both next patterns and the port A copy enable.
  property p_standby_clear;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_hw_standby |=>
        (port_a_next_pattern == 8'h00 && port_b_next_pattern == 8'h00
         && port_a_copy_enable == 8'h00);
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby did not clear"); // R8 R9 R16

  // The inert address of a shared port A pair reads all ones a cycle later.
  property p_a_shared_lo_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_rd_stb && a_shared && i_addr == tpat_pkg::ADDR_PORT_A_NEXT_LO) |=>
        (o_rd_data == 8'hff);
  endproperty
  a_a_shared_lo_read: assert property (p_a_shared_lo_read) else $error("reserved read wrong"); // R10

  // A split port B pair shows ones in the low nibble of the high address.
  property p_b_split_hi_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_rd_stb && !b_shared && i_addr == tpat_pkg::ADDR_PORT_B_NEXT_HI) |=>
        (o_rd_data[3:0] == 4'hf && o_rd_data[7:4] == $past(port_b_next_pattern[7:4]));
  endproperty
  a_b_split_hi_read: assert property (p_b_split_hi_read) else $error("split read wrong"); // R13

  // A high-address write to a split port A pair leaves the group 0 nibble alone.
  property p_a_split_hi_write;
    @(posedge i_sys_clk) disable iff (i_reset)
      (wr_a_hi_addr && !a_shared && !i_hw_standby) |=>
        (port_a_next_pattern[3:0] == $past(port_a_next_pattern[3:0])
         && port_a_next_pattern[7:4] == $past(i_wr_data[7:4]));
  endproperty
  a_a_split_hi_write: assert property (p_a_split_hi_write) else $error("split write wrong"); // R11

  // With group 3 on channel 1, matches of the other channels leave its nibble alone.
  property p_sel_channel;
    @(posedge i_sys_clk) disable iff (i_reset)
      (sel_g3 == 2'h1 && !i_compare_match[1] && !b_out_wr && !i_hw_standby) |=>
        (port_b_output_values[7:4] == $past(port_b_output_values[7:4]));
  endproperty
  a_sel_channel: assert property (p_sel_channel) else $error("group 3 channel wrong"); // R17

endmodule // timed_pattern_unit

// ---- common/tpat_pkg.sv ----
// Purpose: Shared constants of the timed pattern output unit register side.
// Assumes: 16-bit byte addresses and 8-bit data on the plain register port.
// Notes:   Every offset, field position and reset value is named here once.
package tpat_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_GROUP_TRIGGER_SELECT = 16'hffa1;
  localparam logic [15:0] ADDR_PORT_B_COPY_ENABLE   = 16'hffa2;
  localparam logic [15:0] ADDR_PORT_A_COPY_ENABLE   = 16'hffa3;
  localparam logic [15:0] ADDR_PORT_B_NEXT_HI       = 16'hffa4;
  localparam logic [15:0] ADDR_PORT_A_NEXT_HI       = 16'hffa5;
  localparam logic [15:0] ADDR_PORT_B_NEXT_LO       = 16'hffa6;
  localparam logic [15:0] ADDR_PORT_A_NEXT_LO       = 16'hffa7;
  localparam logic [15:0] ADDR_PORT_A_OUTPUT_VALUES = 16'hffd3;
  localparam logic [15:0] ADDR_PORT_B_OUTPUT_VALUES = 16'hffd6;

  // ----------------------------------------------------------------------
  // Field positions of the trigger select register
  // ----------------------------------------------------------------------
  localparam int GROUP0_SEL_LSB = 0;
  localparam int GROUP1_SEL_LSB = 2;
  localparam int GROUP2_SEL_LSB = 4;
  localparam int GROUP3_SEL_LSB = 6;

  // ----------------------------------------------------------------------
  // Reset values and fixed read values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_NEXT_PATTERN   = 8'h00;
  localparam logic [7:0] RESET_COPY_ENABLE    = 8'h00;
  localparam logic [7:0] RESET_OUTPUT_VALUES  = 8'h00;
  localparam logic [7:0] RESET_TRIGGER_SELECT = 8'hff;
  localparam logic [3:0] RESERVED_NIBBLE      = 4'hf;
  localparam logic [7:0] RESERVED_BYTE        = 8'hff;
  localparam logic [7:0] UNMAPPED_READ        = 8'h00;

endpackage : tpat_pkg

// ---- logic/pattern_port.sv ----
// Purpose: One 8-bit pattern port: next pattern, copy enable and output values.
// Assumes: Triggers are one-cycle pulses; write strobes are decoded by the caller.
// Notes:   Bits with copy enable set ignore software writes to the output values.
module pattern_port (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_hw_standby,
  input  wire logic       i_out_wr,
  input  wire logic       i_en_wr,
  input  wire logic       i_next_wr_hi,
  input  wire logic       i_next_wr_lo,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_trig_lo,
  input  wire logic       i_trig_hi,
  output logic      [7:0] o_out_values,
  output logic      [7:0] o_next,
  output logic      [7:0] o_enable
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] next_q;
  logic [7:0] enable_q;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic [7:0] copy_mask;

  // Next pattern nibbles; hardware standby clears, software standby does not.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      next_q <= tpat_pkg::RESET_NEXT_PATTERN; // R8 R9
    end else if (i_hw_standby) begin
      next_q <= tpat_pkg::RESET_NEXT_PATTERN; // R8 R9
    end else begin
      if (i_next_wr_hi) begin
        next_q[7:4] <= i_wr_data[7:4];
      end
      if (i_next_wr_lo) begin
        next_q[3:0] <= i_wr_data[3:0];
      end
    end
  end

  // Per-bit copy enable, cleared by reset and hardware standby.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      enable_q <= tpat_pkg::RESET_COPY_ENABLE; // R16
    end else if (i_hw_standby) begin
      enable_q <= tpat_pkg::RESET_COPY_ENABLE; // R16
    end else if (i_en_wr) begin
      enable_q <= i_wr_data;
    end
  end

  // Bits that take the next pattern in this cycle: enabled and triggered.
  assign copy_mask = enable_q & {{4{i_trig_hi}}, {4{i_trig_lo}}}; // R6 R7 R14 R18 R20

  // Output value: software reaches only disabled bits, triggers only enabled ones.
  always_comb begin
    out_d = out_q;
    if (i_out_wr) begin
      out_d = (i_wr_data & ~enable_q) | (out_q & enable_q); // R2 R4
    end
    out_d = (next_q & copy_mask) | (out_d & ~copy_mask); // R15
  end

  // Output value register.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      out_q <= tpat_pkg::RESET_OUTPUT_VALUES;
    end else if (i_hw_standby) begin
      out_q <= tpat_pkg::RESET_OUTPUT_VALUES;
    end else begin
      out_q <= out_d;
    end
  end

  assign o_out_values = out_q;
  assign o_next       = next_q;
  assign o_enable     = enable_q;

endmodule // pattern_port

// ---- verification/compare_match_source.sv ----
// Purpose: Timer side model that raises the compare-match events for the pattern unit.
// Assumes: The bench asks for events by raising request bits for one or more cycles.
// Notes:   A held request still gives one single-cycle pulse, as a real compare match does.
module compare_match_source (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [3:0] i_fire_req,
  output logic      [3:0] o_compare_match
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] req_q;

  // Remember last cycle's requests so that only their rising edge makes an event.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      req_q <= 4'h0;
    end else begin
      req_q <= i_fire_req;
    end
  end

  // Each channel pulses for exactly one cycle per request.
  assign o_compare_match = i_fire_req & ~req_q;
endmodule // compare_match_source

// ---- verification/timed_pattern_unit_tb_top.sv ----
// Purpose: Self-checking bench for the timed pattern unit register side.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes:   A bench model of every register predicts reads and pattern outputs.
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module timed_pattern_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals and bench model
  // ----------------------------------------------------------------------
  logic        i_sys_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_hw_standby = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_wr_data = 8'h00;
  logic        i_wr_stb = 1'b0;
  logic        i_rd_stb = 1'b0;
  logic [3:0]  fire_req = 4'h0;
  logic [3:0]  i_compare_match;
  logic [7:0]  o_rd_data, o_port_a_pattern, o_port_b_pattern;
  logic [7:0]  m_sel, m_ena, m_enb, m_na, m_nb, m_oa, m_ob, d;
  logic [7:0]  dir_a = 8'h00;
  logic [7:0]  dir_b = 8'h00;
  logic [15:0] a;
  int          n_mismatch = 0;
  int          compares = 0;
  int          k, seed;
  logic [15:0] amap [10] = '{16'hffa1, 16'hffa2, 16'hffa3, 16'hffa4, 16'hffa5,
                             16'hffa6, 16'hffa7, 16'hffd3, 16'hffd6, 16'h1234};

  // A 4 ns clock.
  always #2 i_sys_clk = ~i_sys_clk;

  timed_pattern_unit timed_pattern_unit_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_hw_standby(i_hw_standby),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .i_compare_match(i_compare_match), .o_rd_data(o_rd_data),
    .o_port_a_pattern(o_port_a_pattern), .o_port_b_pattern(o_port_b_pattern));

  compare_match_source compare_match_source_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_fire_req(fire_req),
    .o_compare_match(i_compare_match));

  // ----------------------------------------------------------------------
  // Expectation functions and bus tasks
  // ----------------------------------------------------------------------
  // Nibble masks of the groups whose selected channel fires.
  function automatic logic [7:0] fmask(logic [7:0] sel, logic [3:0] cm, int g);
    return {{4{cm[sel[2*g+2+:2]]}}, {4{cm[sel[2*g+:2]]}}};
  endfunction

  // Read value of each address in the present trigger layout.
  function automatic logic [7:0] rd_exp(logic [15:0] ad);
    logic sa, sb;
    sa = (m_sel[1:0] == m_sel[3:2]);
    sb = (m_sel[5:4] == m_sel[7:6]);
    case (ad)
      16'hffa1: return m_sel;
      16'hffa2: return m_enb;
      16'hffa3: return m_ena;
      16'hffa4: return sb ? m_nb : {m_nb[7:4], 4'hf};
      16'hffa5: return sa ? m_na : {m_na[7:4], 4'hf};
      16'hffa6: return sb ? 8'hff : {4'hf, m_nb[3:0]};
      16'hffa7: return sa ? 8'hff : {4'hf, m_na[3:0]};
      16'hffd3: return m_oa;
      16'hffd6: return m_ob;
      default:  return 8'h00;
    endcase
  endfunction

  task automatic m_reset();
    m_sel = 8'hff;
    {m_ena, m_enb, m_na, m_nb, m_oa, m_ob} = '0;
  endtask

  // One bus cycle, optionally a write, with compare-match requests beside it.
  task automatic op(input logic wr, input logic [15:0] ad, input logic [7:0] dt,
                    input logic [3:0] cm);
    logic [7:0] fa, fb, ca, cb;
    @(posedge i_sys_clk);
    i_wr_stb <= wr;
    i_addr <= ad;
    i_wr_data <= dt;
    fire_req <= cm;
    @(posedge i_sys_clk);
    i_wr_stb <= 1'b0;
    fire_req <= 4'h0;
    fa = fmask(m_sel, cm, 0);
    fb = fmask(m_sel, cm, 2);
    ca = (m_na & fa) | (m_oa & ~fa);
    cb = (m_nb & fb) | (m_ob & ~fb);
    m_oa = (ca & m_ena) | (((wr && ad == 16'hffd3) ? dt : m_oa) & ~m_ena);
    m_ob = (cb & m_enb) | (((wr && ad == 16'hffd6) ? dt : m_ob) & ~m_enb);
    if (wr) begin
      case (ad)
        16'hffa1: m_sel = dt;
        16'hffa2: m_enb = dt;
        16'hffa3: m_ena = dt;
        16'hffa4: m_nb = (m_sel[5:4] == m_sel[7:6]) ? dt : {dt[7:4], m_nb[3:0]};
        16'hffa5: m_na = (m_sel[1:0] == m_sel[3:2]) ? dt : {dt[7:4], m_na[3:0]};
        16'hffa6: if (m_sel[5:4] != m_sel[7:6]) m_nb = {m_nb[7:4], dt[3:0]};
        16'hffa7: if (m_sel[1:0] != m_sel[3:2]) m_na = {m_na[7:4], dt[3:0]};
        default: ;
      endcase
    end
    @(negedge i_sys_clk);
    `CHK(o_port_a_pattern & dir_a, m_oa & dir_a)
    `CHK(o_port_b_pattern & dir_b, m_ob & dir_b)
  endtask

  // Read one address and check the data stand for one cycle only.
  task automatic rd_chk(input logic [15:0] ad);
    logic [7:0] e;
    e = rd_exp(ad);
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b1;
    i_addr <= ad;
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b0;
    @(negedge i_sys_clk);
    `CHK(o_rd_data, e)
    @(negedge i_sys_clk);
    `CHK(o_rd_data, 8'h00)
  endtask

  task automatic rd_all(input string name);
    foreach (amap[i]) rd_chk(amap[i]);
    $display("test %s done", name);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = $urandom(11867);
    m_reset();
    repeat (8) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    // Software makes every pattern pin an output before pattern traffic starts.
    dir_a <= 8'hff;
    dir_b <= 8'hff;
    rd_all("reset_values");
    // Split triggers, one channel per group, then each channel on its own.
    op(1, 16'hffa1, 8'he4, 4'h0);
    op(1, 16'hffa3, 8'hff, 4'h0);
    op(1, 16'hffa2, 8'hff, 4'h0);
    foreach (amap[i]) op(1, amap[i], 8'ha5 ^ 8'(i * 8'h3c), 4'h0);
    op(1, 16'hffa1, 8'he4, 4'h0);
    op(1, 16'hffa3, 8'hff, 4'h0);
    op(1, 16'hffa2, 8'hff, 4'h0);
    rd_all("split_layout");
    for (k = 0; k < 4; k++) op(0, 16'h0000, 8'h00, 4'(1 << k));
    // Group 3 on channel 1 and group 2 on channel 0, with fresh next nibbles.
    op(1, 16'hffa1, 8'h4e, 4'h0);
    op(1, 16'hffa4, 8'hc3, 4'h0);
    op(1, 16'hffa6, 8'h3c, 4'h0);
    for (k = 0; k < 4; k++) op(0, 16'h0000, 8'h00, 4'(1 << k));
    rd_all("channel_one_select");
    // Shared triggers with partial enables and a write to locked output bits.
    op(1, 16'hffa1, 8'h00, 4'h0);
    op(1, 16'hffa5, 8'h81, 4'h0);
    op(1, 16'hffa7, 8'h7e, 4'h0);
    op(1, 16'hffa3, 8'h33, 4'h0);
    op(1, 16'hffd3, 8'hff, 4'h1);
    op(1, 16'hffd3, 8'h00, 4'h0);
    rd_all("shared_layout");
    for (int i = 0; i < 300; i++) begin
      a = amap[$urandom % 10];
      d = 8'($urandom);
      k = $urandom % 3;
      if (k == 0) op(1, a, d, (a == 16'hffd3 || a == 16'hffd6) ? 4'($urandom) : 4'h0);
      else if (k == 1) op(0, a, d, 4'($urandom));
      else rd_chk(a);
    end
    $display("test random_traffic done");
    @(posedge i_sys_clk);
    i_hw_standby <= 1'b1;
    @(posedge i_sys_clk);
    i_hw_standby <= 1'b0;
    m_reset();
    rd_all("hardware_standby");
    op(1, 16'hffa5, 8'h5a, 4'h0);
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    @(posedge i_sys_clk);
    i_reset <= 1'b0;
    m_reset();
    rd_all("second_reset");
    end_of_test();
  end

  // Cut a hung run short.
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule // timed_pattern_unit_tb_top
